// ===== pvau_pkg.sv
package pvau_pkg;
  localparam int NUM_ALARMS = 4;
  localparam int VAL_W = 16;
  localparam int EXT_W = 18;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] SETPOINT_ADDR = 8'h04;
  localparam logic [7:0] DEAD_ZONE_ADDR = 8'h08;
  localparam logic [7:0] DELAY_ADDR = 8'h0C;
  localparam logic [7:0] RATE_LIMIT_ADDR = 8'h10;
  localparam logic [7:0] SPAN_ADDR = 8'h14;
  localparam logic [7:0] RANGE_LO_ADDR = 8'h18;
  localparam logic [7:0] RANGE_HI_ADDR = 8'h1C;
  localparam logic [7:0] MODE_BASE_ADDR = 8'h20;
  localparam logic [7:0] THRESH_BASE_ADDR = 8'h30;
  localparam logic [7:0] EVENT_ADDR = 8'h40;
  localparam logic [7:0] PV_ADDR = 8'h44;
  localparam int ADDR_STEP_LSB = 2;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CASCADE_BIT = 1;
  localparam int EVENT_ALARM_LSB = 4;

  // Reset values
  localparam logic [15:0] SPAN_RESET = 16'h03E8;
  localparam logic [15:0] RANGE_LO_RESET = 16'hFC18;
  localparam logic [15:0] RANGE_HI_RESET = 16'h03E8;

  typedef enum logic [3:0] {
    PVAU_OFF = 4'h0,
    PVAU_ABS_HI = 4'h1,
    PVAU_ABS_LO = 4'h2,
    PVAU_DEV_HI = 4'h3,
    PVAU_DEV_LO = 4'h4,
    PVAU_BAND = 4'h5,
    PVAU_RANGE = 4'h6,
    PVAU_ABS_HI_W = 4'h7,
    PVAU_ABS_LO_W = 4'h8,
    PVAU_DEV_HI_W = 4'h9,
    PVAU_DEV_LO_W = 4'hA,
    PVAU_BAND_W = 4'hB,
    PVAU_DEV_HI_RW = 4'hC,
    PVAU_DEV_LO_RW = 4'hD,
    PVAU_BAND_RW = 4'hE
  } pvau_mode_t;

  localparam logic [3:0] MODE_MAX = 4'hE;
endpackage

// ===== pvau_limit.sv
// Clamps a stored threshold to the range its alarm type accepts
module pvau_limit (
  // Setting
  input wire logic [3:0] mode_in,
  input wire logic signed [17:0] thr_in,
  // Limits
  input wire logic signed [17:0] span_in,
  input wire logic signed [17:0] range_lo_in,
  input wire logic signed [17:0] range_hi_in,
  // Result
  output logic signed [17:0] thr_out
);
  logic signed [17:0] lo;
  logic signed [17:0] hi;

  always_comb
  begin
    lo = range_lo_in;
    hi = range_hi_in;
    case (pvau_pkg::pvau_mode_t'(mode_in))
      pvau_pkg::PVAU_DEV_HI, pvau_pkg::PVAU_DEV_LO, pvau_pkg::PVAU_DEV_HI_W,
      pvau_pkg::PVAU_DEV_LO_W, pvau_pkg::PVAU_DEV_HI_RW, pvau_pkg::PVAU_DEV_LO_RW:
      begin
        lo = -span_in;
        hi = span_in;
      end
      pvau_pkg::PVAU_BAND, pvau_pkg::PVAU_RANGE, pvau_pkg::PVAU_BAND_W,
      pvau_pkg::PVAU_BAND_RW:
      begin
        lo = '0;
        hi = span_in;
      end
      default:
      begin
        lo = range_lo_in;
        hi = range_hi_in;
      end
    endcase
    if (thr_in < lo)
      thr_out = lo;
    else if (thr_in > hi)
      thr_out = hi;
    else
      thr_out = thr_in;
  end
endmodule

// ===== pvau_alarm.sv
// One alarm evaluator: compare, dead zone, delay count, wait
module pvau_alarm (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Sample and events
  input wire logic sample_in,
  input wire logic start_in,
  input wire logic sp_chg_in,
  input wire logic signed [17:0] pv_in,
  input wire logic signed [17:0] dev_in,
  // Settings
  input wire logic [3:0] mode_in,
  input wire logic signed [17:0] thr_in,
  input wire logic [15:0] dz_in,
  input wire logic [15:0] dly_in,
  // Status
  output logic alarm_out
);
  logic alarm_r, alarm_nxt, wait_r, wait_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic use_dev, use_abs, is_upper, is_wait, is_rewait, is_off, cond;
  logic signed [17:0] x, dz;

  always_comb
  begin
    use_dev = 1'b1;
    use_abs = 1'b0;
    is_upper = 1'b1;
    is_wait = 1'b0;
    is_rewait = 1'b0;
    is_off = 1'b0;
    case (pvau_pkg::pvau_mode_t'(mode_in))
      pvau_pkg::PVAU_ABS_HI: use_dev = 1'b0;
      pvau_pkg::PVAU_ABS_LO: {use_dev, is_upper} = 2'b00;
      pvau_pkg::PVAU_DEV_HI: use_dev = 1'b1;
      pvau_pkg::PVAU_DEV_LO: is_upper = 1'b0;
      pvau_pkg::PVAU_BAND: use_abs = 1'b1;
      pvau_pkg::PVAU_RANGE: {use_abs, is_upper} = 2'b10;
      pvau_pkg::PVAU_ABS_HI_W: {use_dev, is_wait} = 2'b01;
      pvau_pkg::PVAU_ABS_LO_W: {use_dev, is_upper, is_wait} = 3'b001;
      pvau_pkg::PVAU_DEV_HI_W: is_wait = 1'b1;
      pvau_pkg::PVAU_DEV_LO_W: {is_upper, is_wait} = 2'b01;
      pvau_pkg::PVAU_BAND_W: {use_abs, is_wait} = 2'b11;
      pvau_pkg::PVAU_DEV_HI_RW: {is_wait, is_rewait} = 2'b11;
      pvau_pkg::PVAU_DEV_LO_RW: {is_upper, is_wait, is_rewait} = 3'b011;
      pvau_pkg::PVAU_BAND_RW: {use_abs, is_wait, is_rewait} = 3'b111;
      default: is_off = 1'b1;
    endcase
    if (!use_dev)
      x = pv_in;
    else if (use_abs && dev_in < 0)
      x = -dev_in;
    else
      x = dev_in;
    dz = {2'b00, dz_in};
    // Dead zone widens the hold band only, so the trip point stays exact
    if (is_upper)
      cond = alarm_r ? (x > thr_in - dz) : (x > thr_in);
    else
      cond = alarm_r ? (x < thr_in + dz) : (x < thr_in);
  end

  always_comb
  begin
    alarm_nxt = alarm_r;
    cnt_nxt = cnt_r;
    wait_nxt = wait_r;
    if (is_off)
    begin
      alarm_nxt = 1'b0;
      cnt_nxt = '0;
      wait_nxt = 1'b0;
    end
    else
    begin
      if (sample_in)
      begin
        if (wait_r)
        begin
          alarm_nxt = 1'b0;
          cnt_nxt = '0;
          if (!cond)
            wait_nxt = 1'b0;
        end
        else if (!cond)
        begin
          alarm_nxt = 1'b0;
          cnt_nxt = '0;
        end
        else if (!alarm_r)
        begin
          if (cnt_r >= dly_in)
            alarm_nxt = 1'b1;
          else
            cnt_nxt = cnt_r + 16'h0001;
        end
      end
      // Arming a wait wins over a sample in the same cycle
      if ((start_in && is_wait) || (sp_chg_in && is_rewait))
      begin
        wait_nxt = 1'b1;
        alarm_nxt = 1'b0;
        cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      alarm_r <= 1'b0;
      cnt_r <= '0;
      wait_r <= 1'b0;
    end
    else
    begin
      alarm_r <= alarm_nxt;
      cnt_r <= cnt_nxt;
      wait_r <= wait_nxt;
    end
  end

  assign alarm_out = alarm_r;

  property p_off;
    @(posedge clk_in) disable iff (!rst_b_in)
    (mode_in == pvau_pkg::PVAU_OFF) |=> !alarm_out;
  endproperty
  a_off: assert property (p_off) else $error("alarm set while off");

  property p_wait_blocks;
    @(posedge clk_in) disable iff (!rst_b_in)
    wait_r |=> !alarm_out;
  endproperty
  a_wait_blocks: assert property (p_wait_blocks) else $error("alarm during wait");

  property p_delay;
    @(posedge clk_in) disable iff (!rst_b_in)
    $rose(alarm_out) |-> $past(sample_in) && $past(cond) && ($past(cnt_r) >= $past(dly_in));
  endproperty
  a_delay: assert property (p_delay) else $error("alarm before delay count");

  property p_drop;
    @(posedge clk_in) disable iff (!rst_b_in)
    (sample_in && !cond) |=> !alarm_out;
  endproperty
  a_drop: assert property (p_drop) else $error("alarm held without condition");

  property p_per_sample;
    @(posedge clk_in) disable iff (!rst_b_in)
    (!sample_in && !is_off) |=> $stable(alarm_out) || $fell(alarm_out);
  endproperty
  a_per_sample: assert property (p_per_sample) else $error("alarm rose between samples");

  sequence s_leave_cond;
    wait_r && sample_in && !cond && !start_in && !sp_chg_in && !is_off;
  endsequence
  property p_arm;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_leave_cond |=> !wait_r;
  endproperty
  a_arm: assert property (p_arm) else $error("wait not released");
endmodule

// ===== pvau_top.sv
// What this block does
// - each channel has four independent alarms, each with own mode and threshold.
// - host writes a mode code 0 to 14 per alarm.
// - alarms 1 to 4 show in event word bits 4 to 7.
// - mode 0 disables the alarm; its bit stays clear.
// - modes 1 and 7 alarm when value exceeds threshold.
// - modes 2 and 8 alarm when value is below threshold.
// - modes 3, 9, 12 alarm when signed deviation exceeds threshold.
// - modes 4, 10, 13 alarm when signed deviation is below threshold.
// - modes 5, 11, 14 above on absolute deviation; mode 6 below.
// - thresholds clamp to input range, plus/minus span, or zero to span.
// - wait modes 7 to 14 ignore a condition present at control start.
// - re-wait modes 12 to 14 also wait again after a setpoint change.
// - a cascade slave skips the setpoint-change wait.
// - a nonzero setpoint rate limit skips the setpoint-change wait.
// - a dead zone gives hysteresis around the threshold.
// - alarm asserts once qualifying samples exceed the delay count.
// - one dead zone and one delay count serve all four alarms.
// - leaving the condition before the delay ends keeps the alarm off.
// - after a wait, arm only once the condition has first gone away.
// - after a setpoint re-wait, arm only once the condition has gone away.
module pvau_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Samples from the same clock domain
  input wire logic sample_valid_in,
  input wire logic signed [15:0] measured_process_value_in,
  // Status
  output logic [3:0] alarm_status_out
);
  localparam int N = pvau_pkg::NUM_ALARMS;

  logic run_r, run_nxt, cascade_r, cascade_nxt;
  logic signed [15:0] control_setpoint_r, control_setpoint_nxt;
  logic [15:0] dead_zone_r, dead_zone_nxt, delay_r, delay_nxt;
  logic [15:0] rate_limit_r, rate_limit_nxt, span_r, span_nxt;
  logic signed [15:0] range_lo_r, range_lo_nxt, range_hi_r, range_hi_nxt;
  logic signed [15:0] pv_r, pv_nxt;
  logic [3:0] mode_r [N];
  logic [3:0] mode_nxt [N];
  logic signed [15:0] thr_r [N];
  logic signed [15:0] thr_nxt [N];
  logic signed [17:0] thr_lim [N];
  logic [31:0] prdata_r, prdata_nxt;
  logic start_r, start_nxt, sp_chg_r, sp_chg_nxt;
  logic wr_en, rd_setup, addr_ok, is_mode, is_thr;
  logic [1:0] idx;
  logic [3:0] alarm_vec;
  logic [15:0] event_word;
  logic signed [17:0] pv_ext, dev_ext, span_ext, lo_ext, hi_ext;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  assign idx = paddr_in[pvau_pkg::ADDR_STEP_LSB +: 2];
  assign is_mode = (paddr_in[7:4] == pvau_pkg::MODE_BASE_ADDR[7:4]) && (paddr_in[1:0] == 2'b00);
  assign is_thr = (paddr_in[7:4] == pvau_pkg::THRESH_BASE_ADDR[7:4]) && (paddr_in[1:0] == 2'b00);
  assign event_word = {8'h00, alarm_vec, 4'h0};

  always_comb
  begin
    case (paddr_in)
      pvau_pkg::CTRL_ADDR, pvau_pkg::SETPOINT_ADDR, pvau_pkg::DEAD_ZONE_ADDR,
      pvau_pkg::DELAY_ADDR, pvau_pkg::RATE_LIMIT_ADDR, pvau_pkg::SPAN_ADDR,
      pvau_pkg::RANGE_LO_ADDR, pvau_pkg::RANGE_HI_ADDR, pvau_pkg::EVENT_ADDR,
      pvau_pkg::PV_ADDR:
        addr_ok = 1'b1;
      default:
        addr_ok = is_mode || is_thr;
    endcase
  end

  // Zero wait states; an unmapped address answers with an error
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;
  assign prdata_out = prdata_r;
  assign alarm_status_out = alarm_vec;

  always_comb
  begin
    run_nxt = run_r;
    cascade_nxt = cascade_r;
    control_setpoint_nxt = control_setpoint_r;
    dead_zone_nxt = dead_zone_r;
    delay_nxt = delay_r;
    rate_limit_nxt = rate_limit_r;
    span_nxt = span_r;
    range_lo_nxt = range_lo_r;
    range_hi_nxt = range_hi_r;
    pv_nxt = sample_valid_in ? measured_process_value_in : pv_r;
    mode_nxt = mode_r;
    thr_nxt = thr_r;
    start_nxt = 1'b0;
    sp_chg_nxt = 1'b0;
    if (wr_en)
    begin
      case (paddr_in)
        pvau_pkg::CTRL_ADDR:
        begin
          run_nxt = pwdata_in[pvau_pkg::CTRL_RUN_BIT];
          cascade_nxt = pwdata_in[pvau_pkg::CTRL_CASCADE_BIT];
          start_nxt = pwdata_in[pvau_pkg::CTRL_RUN_BIT] && !run_r;
        end
        pvau_pkg::SETPOINT_ADDR:
        begin
          control_setpoint_nxt = pwdata_in[15:0];
          // Setpoint-change wait skipped for a cascade slave or a ramped setpoint
          sp_chg_nxt = (pwdata_in[15:0] != control_setpoint_r) && run_r
                       && !cascade_r && (rate_limit_r == 16'h0000);
        end
        pvau_pkg::DEAD_ZONE_ADDR: dead_zone_nxt = pwdata_in[15:0];
        pvau_pkg::DELAY_ADDR: delay_nxt = pwdata_in[15:0];
        pvau_pkg::RATE_LIMIT_ADDR: rate_limit_nxt = pwdata_in[15:0];
        pvau_pkg::SPAN_ADDR: span_nxt = pwdata_in[15:0];
        pvau_pkg::RANGE_LO_ADDR: range_lo_nxt = pwdata_in[15:0];
        pvau_pkg::RANGE_HI_ADDR: range_hi_nxt = pwdata_in[15:0];
        default:
        begin
          // Codes above the last mode are dropped, the old mode stays
          if (is_mode && pwdata_in[31:4] == 28'h000_0000 && pwdata_in[3:0] <= pvau_pkg::MODE_MAX)
            mode_nxt[idx] = pwdata_in[3:0];
          if (is_thr)
            thr_nxt[idx] = pwdata_in[15:0];
        end
      endcase
    end
  end

  always_comb
  begin
    prdata_nxt = prdata_r;
    if (rd_setup)
    begin
      case (paddr_in)
        pvau_pkg::CTRL_ADDR: prdata_nxt = {30'h0000_0000, cascade_r, run_r};
        pvau_pkg::SETPOINT_ADDR: prdata_nxt = {16'h0000, control_setpoint_r};
        pvau_pkg::DEAD_ZONE_ADDR: prdata_nxt = {16'h0000, dead_zone_r};
        pvau_pkg::DELAY_ADDR: prdata_nxt = {16'h0000, delay_r};
        pvau_pkg::RATE_LIMIT_ADDR: prdata_nxt = {16'h0000, rate_limit_r};
        pvau_pkg::SPAN_ADDR: prdata_nxt = {16'h0000, span_r};
        pvau_pkg::RANGE_LO_ADDR: prdata_nxt = {16'h0000, range_lo_r};
        pvau_pkg::RANGE_HI_ADDR: prdata_nxt = {16'h0000, range_hi_r};
        pvau_pkg::EVENT_ADDR: prdata_nxt = {16'h0000, event_word};
        pvau_pkg::PV_ADDR: prdata_nxt = {16'h0000, pv_r};
        default:
        begin
          if (is_mode)
            prdata_nxt = {28'h000_0000, mode_r[idx]};
          else if (is_thr)
            prdata_nxt = {16'h0000, thr_r[idx]};
          else
            prdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      run_r <= 1'b0;
      cascade_r <= 1'b0;
      control_setpoint_r <= '0;
      dead_zone_r <= '0;
      delay_r <= '0;
      rate_limit_r <= '0;
      span_r <= pvau_pkg::SPAN_RESET;
      range_lo_r <= pvau_pkg::RANGE_LO_RESET;
      range_hi_r <= pvau_pkg::RANGE_HI_RESET;
      pv_r <= '0;
      prdata_r <= '0;
      start_r <= 1'b0;
      sp_chg_r <= 1'b0;
      for (int i = 0; i < N; i++)
      begin
        mode_r[i] <= pvau_pkg::PVAU_OFF;
        thr_r[i] <= '0;
      end
    end
    else
    begin
      run_r <= run_nxt;
      cascade_r <= cascade_nxt;
      control_setpoint_r <= control_setpoint_nxt;
      dead_zone_r <= dead_zone_nxt;
      delay_r <= delay_nxt;
      rate_limit_r <= rate_limit_nxt;
      span_r <= span_nxt;
      range_lo_r <= range_lo_nxt;
      range_hi_r <= range_hi_nxt;
      pv_r <= pv_nxt;
      prdata_r <= prdata_nxt;
      start_r <= start_nxt;
      sp_chg_r <= sp_chg_nxt;
      mode_r <= mode_nxt;
      thr_r <= thr_nxt;
    end
  end

  assign pv_ext = {{2{measured_process_value_in[15]}}, measured_process_value_in};
  assign dev_ext = pv_ext - {{2{control_setpoint_r[15]}}, control_setpoint_r};
  assign span_ext = {2'b00, span_r};
  assign lo_ext = {{2{range_lo_r[15]}}, range_lo_r};
  assign hi_ext = {{2{range_hi_r[15]}}, range_hi_r};

  for (genvar g = 0; g < N; g++)
  begin : g_alarm
    pvau_limit u_limit (
      .mode_in(mode_r[g]),
      .thr_in({{2{thr_r[g][15]}}, thr_r[g]}),
      .span_in(span_ext),
      .range_lo_in(lo_ext),
      .range_hi_in(hi_ext),
      .thr_out(thr_lim[g])
    );

    pvau_alarm u_alarm (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .sample_in(sample_valid_in),
      .start_in(start_r),
      .sp_chg_in(sp_chg_r),
      .pv_in(pv_ext),
      .dev_in(dev_ext),
      .mode_in(mode_r[g]),
      .thr_in(thr_lim[g]),
      .dz_in(dead_zone_r),
      .dly_in(delay_r),
      .alarm_out(alarm_vec[g])
    );

    property p_limit;
      @(posedge clk_in) disable iff (!rst_b_in)
      (mode_r[g] inside {4'h5, 4'h6, 4'hB, 4'hE}) |-> (thr_lim[g] >= 0) && (thr_lim[g] <= span_ext);
    endproperty
    a_limit: assert property (p_limit) else $error("threshold outside span");

    property p_limit_dev;
      @(posedge clk_in) disable iff (!rst_b_in)
      (mode_r[g] inside {pvau_pkg::PVAU_DEV_HI, pvau_pkg::PVAU_DEV_LO, pvau_pkg::PVAU_DEV_HI_W,
        pvau_pkg::PVAU_DEV_LO_W, pvau_pkg::PVAU_DEV_HI_RW, pvau_pkg::PVAU_DEV_LO_RW})
        |-> (thr_lim[g] >= -span_ext) && (thr_lim[g] <= span_ext);
    endproperty
    a_limit_dev: assert property (p_limit_dev) else $error("threshold beyond span");

    property p_mode_write;
      @(posedge clk_in) disable iff (!rst_b_in)
      (wr_en && is_mode && idx == 2'(g) && pwdata_in[31:4] == 28'h000_0000
        && pwdata_in[3:0] <= pvau_pkg::MODE_MAX) |=> mode_r[g] == $past(pwdata_in[3:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_thr_write;
      @(posedge clk_in) disable iff (!rst_b_in)
      (wr_en && is_thr && idx == 2'(g)) |=> thr_r[g] == $past(pwdata_in[15:0]);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write lost");
  end

  property p_mode_range;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr_en && is_mode && pwdata_in[3:0] > pvau_pkg::MODE_MAX) |=> $stable(mode_r[idx]);
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("bad mode accepted");

  property p_event_read;
    @(posedge clk_in) disable iff (!rst_b_in)
    (rd_setup && paddr_in == pvau_pkg::EVENT_ADDR)
      |=> prdata_out[7:4] == $past(alarm_vec) && prdata_out[3:0] == 4'h0;
  endproperty
  a_event_read: assert property (p_event_read) else $error("event bits misplaced");

  property p_no_rewait;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr_en && paddr_in == pvau_pkg::SETPOINT_ADDR && (cascade_r || rate_limit_r != 16'h0000))
      |=> !sp_chg_r;
  endproperty
  a_no_rewait: assert property (p_no_rewait) else $error("re-wait on slave or ramp");

  // Both wait triggers are one-cycle pulses into every evaluator
  sequence s_start_write;
    wr_en && paddr_in == pvau_pkg::CTRL_ADDR && pwdata_in[pvau_pkg::CTRL_RUN_BIT] && !run_r;
  endsequence
  property p_start_arm;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_start_write |=> start_r ##1 !start_r;
  endproperty
  a_start_arm: assert property (p_start_arm) else $error("control start pulse wrong");

  sequence s_sp_write;
    wr_en && paddr_in == pvau_pkg::SETPOINT_ADDR && pwdata_in[15:0] != control_setpoint_r
      && run_r && !cascade_r && rate_limit_r == 16'h0000;
  endsequence
  property p_sp_arm;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_sp_write |=> sp_chg_r ##1 !sp_chg_r;
  endproperty
  a_sp_arm: assert property (p_sp_arm) else $error("setpoint re-wait pulse wrong");
endmodule

// ===== pvau_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_valid = 1'b0;
  logic signed [15:0] pv = 16'h0000;
  logic [3:0] status;
  int fails = 0;
  int n_compared = 0;

  pvau_top dut_u (
    .clk_in(clk),
    .rst_b_in(rst_b),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .sample_valid_in(sample_valid),
    .measured_process_value_in(pv),
    .alarm_status_out(status)
  );

  always #4 clk = ~clk;

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk1("pready", 1'b1, pready);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk32(what, exp, q);
    chk1("pslverr", err, e);
  endtask

  task automatic set_alarm(input int i, input logic [3:0] m, input logic [15:0] t);
    wr(pvau_pkg::MODE_BASE_ADDR + 8'(i * 4), {28'h000_0000, m});
    wr(pvau_pkg::THRESH_BASE_ADDR + 8'(i * 4), {16'h0000, t});
  endtask

  // One idle cycle between samples keeps the strobe a clean pulse
  task automatic samp(input logic [15:0] v, input logic [3:0] exp);
    @(posedge clk);
    sample_valid <= 1'b1;
    pv <= v;
    @(posedge clk);
    sample_valid <= 1'b0;
    #1;
    chk4("alarm status", exp, status);
  endtask

  // Wait arming is a registered pulse, so allow a few edges to land
  task automatic settle(input logic [3:0] exp);
    repeat (3) @(posedge clk);
    #1;
    chk4("status after write", exp, status);
  endtask

  task automatic clear_modes();
    for (int i = 0; i < 4; i++)
    begin
      wr(pvau_pkg::MODE_BASE_ADDR + 8'(i * 4), 32'h0000_0000);
    end
    settle(4'h0);
  endtask

  task automatic t_reset();
    chk4("status at reset", 4'h0, status);
    rd_chk("span", pvau_pkg::SPAN_ADDR, 32'h0000_03E8, 1'b0);
    rd_chk("range low", pvau_pkg::RANGE_LO_ADDR, 32'h0000_FC18, 1'b0);
    rd_chk("range high", pvau_pkg::RANGE_HI_ADDR, 32'h0000_03E8, 1'b0);
    rd_chk("mode 4", pvau_pkg::MODE_BASE_ADDR + 8'h0C, 32'h0000_0000, 1'b0);
    rd_chk("event", pvau_pkg::EVENT_ADDR, 32'h0000_0000, 1'b0);
    rd_chk("unmapped", 8'h48, 32'h0000_0000, 1'b1);
    $display("test reset values done");
  endtask

  task automatic t_levels();
    wr(pvau_pkg::CTRL_ADDR, 32'h0000_0001);
    wr(pvau_pkg::SETPOINT_ADDR, 32'h0000_0032);
    set_alarm(0, pvau_pkg::PVAU_ABS_HI, 16'h0064);
    set_alarm(1, pvau_pkg::PVAU_ABS_LO, 16'h0000);
    set_alarm(2, pvau_pkg::PVAU_DEV_HI, 16'h0014);
    set_alarm(3, pvau_pkg::PVAU_DEV_LO, 16'hFFEC);
    samp(16'h0032, 4'h0);
    samp(16'h0046, 4'h0);
    samp(16'h001E, 4'h0);
    samp(16'h0064, 4'h4);
    samp(16'h0065, 4'h5);
    samp(16'h0000, 4'h8);
    samp(16'hFFFF, 4'hA);
    rd_chk("event word", pvau_pkg::EVENT_ADDR, 32'h0000_00A0, 1'b0);
    rd_chk("last sample", pvau_pkg::PV_ADDR, 32'h0000_FFFF, 1'b0);
    $display("test level alarms done");
  endtask

  task automatic t_bands();
    clear_modes();
    set_alarm(0, pvau_pkg::PVAU_BAND, 16'h0014);
    set_alarm(1, pvau_pkg::PVAU_RANGE, 16'h0014);
    set_alarm(2, pvau_pkg::PVAU_OFF, 16'h0000);
    set_alarm(3, pvau_pkg::PVAU_BAND, 16'h1388);
    samp(16'h0032, 4'h2);
    samp(16'h0047, 4'h1);
    samp(16'h001D, 4'h1);
    samp(16'h060E, 4'h9);
    wr(pvau_pkg::MODE_BASE_ADDR, 32'h0000_000F);
    rd_chk("mode above 14", pvau_pkg::MODE_BASE_ADDR, 32'h0000_0005, 1'b0);
    $display("test band alarms done");
  endtask

  task automatic t_wait();
    clear_modes();
    wr(pvau_pkg::CTRL_ADDR, 32'h0000_0000);
    set_alarm(0, pvau_pkg::PVAU_ABS_HI_W, 16'h0064);
    set_alarm(1, pvau_pkg::PVAU_ABS_LO_W, 16'h012C);
    set_alarm(2, pvau_pkg::PVAU_DEV_HI_W, 16'h0014);
    set_alarm(3, pvau_pkg::PVAU_BAND_W, 16'h0014);
    wr(pvau_pkg::CTRL_ADDR, 32'h0000_0001);
    samp(16'h00C8, 4'h0);
    samp(16'h00C8, 4'h0);
    samp(16'h0032, 4'h0);
    samp(16'h00C8, 4'hD);
    samp(16'h0190, 4'hD);
    samp(16'h00FA, 4'hF);
    $display("test wait done");
  endtask

  task automatic t_rewait();
    clear_modes();
    wr(pvau_pkg::CTRL_ADDR, 32'h0000_0000);
    wr(pvau_pkg::SETPOINT_ADDR, 32'h0000_0000);
    set_alarm(0, pvau_pkg::PVAU_DEV_HI_RW, 16'h000A);
    set_alarm(1, pvau_pkg::PVAU_DEV_LO_RW, 16'hFFF6);
    set_alarm(2, pvau_pkg::PVAU_BAND_RW, 16'h000A);
    set_alarm(3, pvau_pkg::PVAU_DEV_LO_W, 16'hFFF6);
    wr(pvau_pkg::CTRL_ADDR, 32'h0000_0001);
    samp(16'h0000, 4'h0);
    samp(16'h0014, 4'h5);
    wr(pvau_pkg::SETPOINT_ADDR, 32'h0000_0005);
    settle(4'h0);
    samp(16'h0014, 4'h0);
    samp(16'hFFEC, 4'hA);
    samp(16'h0005, 4'h0);
    samp(16'h0014, 4'h5);
    wr(pvau_pkg::RATE_LIMIT_ADDR, 32'h0000_0001);
    wr(pvau_pkg::SETPOINT_ADDR, 32'h0000_0006);
    settle(4'h5);
    samp(16'h0014, 4'h5);
    wr(pvau_pkg::RATE_LIMIT_ADDR, 32'h0000_0000);
    wr(pvau_pkg::CTRL_ADDR, 32'h0000_0003);
    wr(pvau_pkg::SETPOINT_ADDR, 32'h0000_0007);
    settle(4'h5);
    samp(16'h0014, 4'h5);
    $display("test re-wait done");
  endtask

  task automatic t_filter();
    clear_modes();
    set_alarm(0, pvau_pkg::PVAU_ABS_HI, 16'h0064);
    set_alarm(1, pvau_pkg::PVAU_ABS_HI, 16'h0064);
    wr(pvau_pkg::DEAD_ZONE_ADDR, 32'h0000_000A);
    wr(pvau_pkg::DELAY_ADDR, 32'h0000_0002);
    samp(16'h0065, 4'h0);
    samp(16'h0065, 4'h0);
    samp(16'h0032, 4'h0);
    samp(16'h0065, 4'h0);
    samp(16'h0065, 4'h0);
    samp(16'h0065, 4'h3);
    samp(16'h005F, 4'h3);
    samp(16'h0059, 4'h0);
    samp(16'h005F, 4'h0);
    $display("test dead zone and delay done");
  endtask

  initial
  begin
    #100000;
    fails++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_levels();
    t_bands();
    t_wait();
    t_rewait();
    t_filter();
    complete_run();
  end
endmodule
